// [src/ptsc_cmd.sv]
// ptsc_cmd: command fifo and interpreter for open pipe, radio test, state dump and restore
// assumes command bytes arrive as length, opcode, payload, all on core_clk_in
`timescale 1ns/1ps

module ptsc_fifo #(
  parameter int W = 8,
  parameter int D = ptsc_pkg::FIFO_DEPTH
) (
  input  wire logic         core_clk_in,
  input  wire logic         nrst_in,
  input  wire logic         in_valid_in,
  output logic              in_ready_out,
  input  wire logic [W-1:0] in_data_in,
  output logic              out_valid_out,
  input  wire logic         out_ready_in,
  output logic [W-1:0]      out_data_out
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
    logic                room;
  } ptsc_fifo_s;
  ptsc_fifo_s r, n;
  logic push, pop;

  always_comb begin
    n = r;
    push = in_valid_in && r.room;
    pop = out_ready_in && (r.cnt != '0);
    if (push) begin
      n.mem[r.wp] = in_data_in;
      n.wp = r.wp + 1'b1;
    end
    if (pop) begin
      n.rp = r.rp + 1'b1;
    end
    n.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    n.room = (n.cnt != (AW+1)'(D));
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      r <= '0;
      r.room <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign in_ready_out = r.room;
  assign out_valid_out = (r.cnt != '0);
  assign out_data_out = r.mem[r.rp];
endmodule // ptsc_fifo

module ptsc_cmd (
  input  wire logic                   core_clk_in,
  input  wire logic                   nrst_in,
  input  wire logic                   cmd_valid_in,
  output logic                        cmd_ready_out,
  input  wire logic [7:0]             cmd_byte_in,
  output logic                        evt_valid_out,
  input  wire logic                   evt_ready_in,
  output logic [7:0]                  evt_byte_out,
  input  wire logic                   closed_load_in,
  input  wire logic [ptsc_pkg::PIPES-1:0] closed_map_in,
  output logic                        open_req_out,
  output logic [5:0]                  open_pipe_out,
  input  wire logic                   open_done_in,
  input  wire logic                   open_ok_in,
  output logic [ptsc_pkg::PIPES-1:0]  open_map_out,
  output logic [ptsc_pkg::PIPES-1:0]  closed_pipe_map_out,
  input  wire ptsc_pkg::ptsc_rx_s     peer_rx_in,
  output ptsc_pkg::ptsc_rx_s          deliver_out,
  output ptsc_pkg::ptsc_radio_s       radio_out,
  input  wire logic                   radio_done_in,
  input  wire logic                   radio_ok_in,
  input  wire logic [15:0]            radio_evt_in,
  output logic                        carrier_out,
  input  wire logic                   uart_req_in,
  input  wire logic [15:0]            uart_cmd_in,
  output logic                        uart_ready_out,
  output logic                        uart_rsp_valid_out,
  output logic [15:0]                 uart_rsp_out,
  input  wire logic [5:0]             mem_addr_in,
  output logic [7:0]                  mem_rdata_out,
  output logic                        state_restored_out
);
  ptsc_pkg::ptsc_st_s r, n;
  logic       f_valid, f_pop;
  logic [7:0] f_byte;
  logic       uart_go, host_go, len_bad;
  logic [15:0] rc;
  int         nb;

  ptsc_fifo #(.W(8), .D(ptsc_pkg::FIFO_DEPTH)) u_fifo (
    .core_clk_in   (core_clk_in),
    .nrst_in       (nrst_in),
    .in_valid_in   (cmd_valid_in),
    .in_ready_out  (cmd_ready_out),
    .in_data_in    (cmd_byte_in),
    .out_valid_out (f_valid),
    .out_ready_in  (f_pop),
    .out_data_out  (f_byte)
  );

  function automatic logic cw_sel(input logic [15:0] c);
    cw_sel = (c[15:14] == ptsc_pkg::DTM_TX) && (c[1:0] == ptsc_pkg::PKT_CW);
  endfunction

  always_comb begin
    n = r;
    rc = {r.arg[0], r.arg[1]};
    nb = int'(r.len) - 2;
    f_pop = r.st inside {ptsc_pkg::S_LEN, ptsc_pkg::S_OP, ptsc_pkg::S_ARG};
    n.open_req = 1'b0;
    n.radio.req = 1'b0;
    n.uart_v = 1'b0;
    n.mem_rd = r.mem[mem_addr_in];
    // receive data only on opened pipes
    n.rx.valid = peer_rx_in.valid && r.openm[peer_rx_in.pipe];
    n.rx.pipe = peer_rx_in.pipe;
    n.rx.data = peer_rx_in.data;
    if (closed_load_in) begin
      n.closedm = closed_map_in;
      n.openm = '0;
    end
    len_bad = 1'b0;
    case (r.op)
      ptsc_pkg::OP_OPEN:    len_bad = r.len != ptsc_pkg::LEN_OPEN;
      ptsc_pkg::OP_RADIO:   len_bad = r.len != ptsc_pkg::LEN_RADIO;
      ptsc_pkg::OP_DUMP:    len_bad = r.len != ptsc_pkg::LEN_DUMP;
      ptsc_pkg::OP_RESTORE: len_bad = (r.len < ptsc_pkg::LEN_RS_MIN) ||
                                      (r.len > ptsc_pkg::LEN_RS_MAX);
      default:              len_bad = 1'b1;
    endcase
    // serial test path shares the radio; uart ready drops while a host test waits in S_DO, so the host wins a tie
    uart_go = uart_req_in && r.uart_rdy;
    host_go = (r.st == ptsc_pkg::S_DO) && !len_bad && (r.op == ptsc_pkg::OP_RADIO) &&
              !r.rbusy && !uart_go;
    if (uart_go) begin
      n.radio.req = 1'b1;
      n.radio.cmd = uart_cmd_in;
      n.carrier = cw_sel(uart_cmd_in);
      n.rbusy = 1'b1;
      n.rown_uart = 1'b1;
    end else if (host_go) begin
      n.radio.req = 1'b1;
      n.radio.cmd = rc;
      n.carrier = cw_sel(rc);
      n.rbusy = 1'b1;
      n.rown_uart = 1'b0;
    end
    if (radio_done_in && r.rbusy && r.rown_uart) begin
      n.rbusy = 1'b0;
      n.uart_v = 1'b1;
      n.uart_evt = radio_evt_in;
    end
    case (r.st)
      ptsc_pkg::S_LEN: begin
        if (f_valid) begin
          n.len = f_byte;
          n.cnt = '0;
          n.st = ptsc_pkg::S_OP;
        end
      end
      ptsc_pkg::S_OP: begin
        if (f_valid) begin
          n.op = f_byte;
          n.st = (r.len <= 8'h01) ? ptsc_pkg::S_DO : ptsc_pkg::S_ARG;
        end
      end
      ptsc_pkg::S_ARG: begin
        if (f_valid) begin
          if (int'(r.cnt) < ptsc_pkg::ARGS) begin
            n.arg[r.cnt[4:0]] = f_byte;
          end
          n.cnt = r.cnt + 8'h01;
          if (r.cnt + 8'h02 >= r.len) begin
            n.st = ptsc_pkg::S_DO;
          end
        end
      end
      ptsc_pkg::S_DO: begin
        n.ebuf = '0;
        n.ebuf[0] = 8'h03;
        n.ebuf[1] = ptsc_pkg::EV_REPLY;
        n.ebuf[2] = r.op;
        n.ebuf[3] = ptsc_pkg::ST_ERR;
        n.st = ptsc_pkg::S_TX;
        if (len_bad) begin
          n.ebuf[3] = ptsc_pkg::ST_ERR;
        end else if (r.op == ptsc_pkg::OP_OPEN) begin
          if (r.arg[0] < 8'h40 && r.closedm[r.arg[0][5:0]]) begin
            n.open_req = 1'b1;
            n.st = ptsc_pkg::S_WAIT;
          end
        end else if (r.op == ptsc_pkg::OP_RADIO) begin
          n.st = host_go ? ptsc_pkg::S_WAIT : ptsc_pkg::S_DO;
        end else if (r.op == ptsc_pkg::OP_DUMP) begin
          // one packet per command: sequence byte then a full chunk
          n.ebuf[0] = 8'(4 + ptsc_pkg::CHUNK);
          n.ebuf[4] = r.dseq;
          for (int i = 0; i < ptsc_pkg::CHUNK; i++) begin
            n.ebuf[5+i] = r.mem[int'(r.dseq[0]) * ptsc_pkg::CHUNK + i];
          end
          if (r.dseq == ptsc_pkg::LAST_SEQ) begin
            n.ebuf[3] = ptsc_pkg::ST_DONE;
            n.dseq = '0;
          end else begin
            n.ebuf[3] = ptsc_pkg::ST_CONT;
            n.dseq = r.dseq + 8'h01;
          end
        end else begin
          if (r.arg[0] == r.rseq) begin
            for (int i = 0; i < ptsc_pkg::CHUNK; i++) begin
              if (i < nb) begin
                n.mem[int'(r.rseq[0]) * ptsc_pkg::CHUNK + i] = r.arg[1+i];
              end
            end
            if (r.rseq == ptsc_pkg::LAST_SEQ) begin
              n.ebuf[3] = ptsc_pkg::ST_DONE;
              n.rseq = '0;
              n.restored = 1'b1;
            end else begin
              n.ebuf[3] = ptsc_pkg::ST_CONT;
              n.rseq = r.rseq + 8'h01;
            end
          end else begin
            n.rseq = '0;
          end
        end
      end
      ptsc_pkg::S_WAIT: begin
        if (r.op == ptsc_pkg::OP_OPEN && open_done_in) begin
          n.ebuf[3] = open_ok_in ? ptsc_pkg::ST_OK : ptsc_pkg::ST_ERR;
          n.fol_ps = open_ok_in;
          n.fol_pf = !open_ok_in;
          if (open_ok_in) begin
            n.openm[r.arg[0][5:0]] = 1'b1;
            n.closedm[r.arg[0][5:0]] = 1'b0;
          end
          n.st = ptsc_pkg::S_TX;
        end else if (r.op == ptsc_pkg::OP_RADIO && radio_done_in && !r.rown_uart) begin
          n.rbusy = 1'b0;
          n.ebuf[3] = radio_ok_in ? ptsc_pkg::ST_OK : ptsc_pkg::ST_ERR;
          n.ebuf[0] = radio_ok_in ? 8'h05 : 8'h03;
          n.ebuf[4] = radio_evt_in[15:8];
          n.ebuf[5] = radio_evt_in[7:0];
          n.st = ptsc_pkg::S_TX;
        end
      end
      ptsc_pkg::S_TX: begin
        if (!r.ev_v) begin
          n.ev_v = 1'b1;
          n.ev_b = r.ebuf[0];
          n.idx = 6'h01;
        end else if (evt_ready_in) begin
          if (r.idx == 6'(r.ebuf[0]) + 6'h01) begin
            n.ev_v = 1'b0;
            n.st = ptsc_pkg::S_LEN;
            if (r.fol_ps) begin
              n.fol_ps = 1'b0;
              n.ebuf[0] = 8'h11;
              n.ebuf[1] = ptsc_pkg::EV_PSTATE;
              for (int i = 0; i < 8; i++) begin
                n.ebuf[2+i] = r.openm[8*i +: 8];
                n.ebuf[10+i] = r.closedm[8*i +: 8];
              end
              n.st = ptsc_pkg::S_TX;
            end else if (r.fol_pf) begin
              n.fol_pf = 1'b0;
              n.ebuf[0] = 8'h03;
              n.ebuf[1] = ptsc_pkg::EV_PFAULT;
              n.ebuf[2] = r.arg[0];
              n.ebuf[3] = ptsc_pkg::ST_ERR;
              n.st = ptsc_pkg::S_TX;
            end
          end else begin
            n.ev_b = r.ebuf[r.idx[4:0]];
            n.idx = r.idx + 6'h01;
          end
        end
      end
      default: n.st = ptsc_pkg::S_LEN;
    endcase
    n.uart_rdy = !n.rbusy && !((n.st == ptsc_pkg::S_DO) && (n.op == ptsc_pkg::OP_RADIO));
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      r <= '0;
      r.st <= ptsc_pkg::S_LEN;
    end else begin
      r <= n;
    end
  end

  assign evt_valid_out = r.ev_v;
  assign evt_byte_out = r.ev_b;
  assign open_req_out = r.open_req;
  assign open_pipe_out = r.arg[0][5:0];
  assign open_map_out = r.openm;
  assign closed_pipe_map_out = r.closedm;
  assign deliver_out = r.rx;
  assign radio_out = r.radio;
  assign carrier_out = r.carrier;
  assign uart_ready_out = r.uart_rdy;
  assign uart_rsp_valid_out = r.uart_v;
  assign uart_rsp_out = r.uart_evt;
  assign mem_rdata_out = r.mem_rd;
  assign state_restored_out = r.restored;

  sequence s_open_ok;
    r.st == ptsc_pkg::S_DO && !len_bad && r.op == ptsc_pkg::OP_OPEN &&
      r.arg[0] < 8'h40 && r.closedm[r.arg[0][5:0]];
  endsequence
  sequence s_dump;
    r.st == ptsc_pkg::S_DO && !len_bad && r.op == ptsc_pkg::OP_DUMP;
  endsequence

  property p_rx_gate;
    @(posedge core_clk_in) disable iff (!nrst_in)
      peer_rx_in.valid && !r.openm[peer_rx_in.pipe] |=> !deliver_out.valid;
  endproperty
  a_rx_gate: assert property (p_rx_gate) else $error("closed pipe delivered");
  property p_open_req;
    @(posedge core_clk_in) disable iff (!nrst_in)
      s_open_ok |=> open_req_out && r.st == ptsc_pkg::S_WAIT;
  endproperty
  a_open_req: assert property (p_open_req) else $error("open not issued");
  property p_open_fault;
    @(posedge core_clk_in) disable iff (!nrst_in)
      r.st == ptsc_pkg::S_WAIT && r.op == ptsc_pkg::OP_OPEN && open_done_in && !open_ok_in
      |=> r.fol_pf && !r.fol_ps && r.ebuf[3] == ptsc_pkg::ST_ERR;
  endproperty
  a_open_fault: assert property (p_open_fault) else $error("fault not queued");
  property p_len_err;
    @(posedge core_clk_in) disable iff (!nrst_in)
      r.st == ptsc_pkg::S_DO && len_bad
      |=> r.st == ptsc_pkg::S_TX && r.ebuf[3] == ptsc_pkg::ST_ERR && !open_req_out;
  endproperty
  a_len_err: assert property (p_len_err) else $error("bad length not refused");
  property p_radio_cmd;
    @(posedge core_clk_in) disable iff (!nrst_in)
      host_go |=> radio_out.req && radio_out.cmd == $past(rc);
  endproperty
  a_radio_cmd: assert property (p_radio_cmd) else $error("radio cmd wrong");
  property p_carrier;
    @(posedge core_clk_in) disable iff (!nrst_in)
      radio_out.req |-> carrier_out == cw_sel(radio_out.cmd);
  endproperty
  a_carrier: assert property (p_carrier) else $error("carrier mismatch");
  property p_uart;
    @(posedge core_clk_in) disable iff (!nrst_in)
      uart_req_in && uart_ready_out |=> radio_out.req ##1 !uart_ready_out;
  endproperty
  a_uart: assert property (p_uart) else $error("serial test not run");
  property p_dump;
    @(posedge core_clk_in) disable iff (!nrst_in)
      s_dump |=> r.ebuf[4] == $past(r.dseq) && r.ebuf[0] == 8'h1f &&
        (r.ebuf[3] == ptsc_pkg::ST_CONT || r.ebuf[3] == ptsc_pkg::ST_DONE);
  endproperty
  a_dump: assert property (p_dump) else $error("dump reply wrong");
  property p_radio_rsp;
    @(posedge core_clk_in) disable iff (!nrst_in)
      r.st == ptsc_pkg::S_WAIT && r.op == ptsc_pkg::OP_RADIO && radio_done_in &&
      radio_ok_in && !r.rown_uart |=> r.ebuf[4] == $past(radio_evt_in[15:8]);
  endproperty
  a_radio_rsp: assert property (p_radio_rsp) else $error("test event order");
endmodule // ptsc_cmd

// [src/ptsc_pkg.sv]
// ptsc_pkg: constants, state encoding and carriers for the pipe/test/state command block
// assumes one 200 MHz clock and byte streams from same-clock transport logic
// Operation
// - open-receive-pipe is opcode 0x14, length 2, one pipe identifier byte.
// - remote receive pipes start closed; no peer data delivered until opened.
// - open answers command reply, then pipe state event with updated bitmaps.
// - a failed open sends pipe fault event instead of pipe state event; code sends it only on link failure, not for a pipe not in the closed map.
// - radio test is opcode 0x03, length 3, two-byte command, MSB first.
// - radio test result returns in command reply: status, two-byte event MSB first.
// - transmitter test with payload code 11 gives continuous unmodulated carrier.
// - the serial test path can invoke the same radio test operations.
// - state-dump is opcode 0x07, length 1, no parameters.
// - state is dumped one packet per command until all is read.
// - dump status is continue, complete on last packet, or failure.
// - dump reply holds one sequence byte then 1 to 27 state bytes.
// - state-restore is opcode 0x08, repeated until all state written back.
// - after full restore the device resumes the dumped state.
// - restore carries sequence byte then data; reply continue, complete or error.
package ptsc_pkg;
  localparam logic [7:0] OP_OPEN    = 8'h14;
  localparam logic [7:0] OP_RADIO   = 8'h03;
  localparam logic [7:0] OP_DUMP    = 8'h07;
  localparam logic [7:0] OP_RESTORE = 8'h08;
  localparam logic [7:0] LEN_OPEN   = 8'h02;
  localparam logic [7:0] LEN_RADIO  = 8'h03;
  localparam logic [7:0] LEN_DUMP   = 8'h01;
  localparam logic [7:0] LEN_RS_MIN = 8'h03;
  localparam logic [7:0] LEN_RS_MAX = 8'h1d;
  localparam logic [7:0] EV_REPLY   = 8'h84;
  localparam logic [7:0] EV_PSTATE  = 8'h80;
  localparam logic [7:0] EV_PFAULT  = 8'h8d;
  localparam logic [7:0] ST_OK      = 8'h00;
  localparam logic [7:0] ST_CONT    = 8'h01;
  localparam logic [7:0] ST_DONE    = 8'h02;
  localparam logic [7:0] ST_ERR     = 8'h83;
  localparam logic [1:0] DTM_TX     = 2'h2;
  localparam logic [1:0] PKT_CW     = 2'h3;
  localparam int CHUNK      = 27;
  localparam int PKTS       = 2;
  localparam int MEM_BYTES  = 54;
  localparam int PIPES      = 64;
  localparam int ARGS       = 28;
  localparam int EBUF       = 32;
  localparam int FIFO_DEPTH = 8;
  localparam logic [7:0] LAST_SEQ = 8'h01;

  typedef enum logic [5:0] {
    S_LEN  = 6'h01,
    S_OP   = 6'h02,
    S_ARG  = 6'h04,
    S_DO   = 6'h08,
    S_WAIT = 6'h10,
    S_TX   = 6'h20
  } ptsc_state_e;

  typedef struct packed {
    logic        req;
    logic [15:0] cmd;
  } ptsc_radio_s;

  typedef struct packed {
    logic       valid;
    logic [5:0] pipe;
    logic [7:0] data;
  } ptsc_rx_s;

  typedef struct packed {
    ptsc_state_e                  st;
    logic [7:0]                   len;
    logic [7:0]                   op;
    logic [7:0]                   cnt;
    logic [ARGS-1:0][7:0]         arg;
    logic [EBUF-1:0][7:0]         ebuf;
    logic [5:0]                   idx;
    logic                         fol_ps;
    logic                         fol_pf;
    logic                         open_req;
    logic [PIPES-1:0]             openm;
    logic [PIPES-1:0]             closedm;
    logic [MEM_BYTES-1:0][7:0]    mem;
    logic [7:0]                   dseq;
    logic [7:0]                   rseq;
    logic                         restored;
    ptsc_radio_s                  radio;
    logic                         rbusy;
    logic                         rown_uart;
    logic                         carrier;
    logic                         uart_rdy;
    logic                         uart_v;
    logic [15:0]                  uart_evt;
    ptsc_rx_s                     rx;
    logic                         ev_v;
    logic [7:0]                   ev_b;
    logic [7:0]                   mem_rd;
  } ptsc_st_s;
endpackage

// [test/ptsc_host.sv]
// ptsc_host: application processor model on the command and event byte streams
// assumes the block takes or gives a byte at each edge where valid and ready are both high
`timescale 1ns/1ps

module ptsc_host (
  input  wire logic       core_clk_in,
  output logic            cmd_valid_out,
  input  wire logic       cmd_ready_in,
  output logic [7:0]      cmd_byte_out,
  input  wire logic       evt_valid_in,
  output logic            evt_ready_out,
  input  wire logic [7:0] evt_byte_in
);
  logic [7:0] rx [32];
  logic       late;

  initial begin
    cmd_valid_out = 1'b0;
    cmd_byte_out  = 8'ha5;
    evt_ready_out = 1'b0;
    late          = 1'b0;
  end

  // whole command, byte held until taken
  task automatic put(input logic [7:0] q[$]);
    int k;
    foreach (q[i]) begin
      cmd_byte_out  = q[i];
      cmd_valid_out = 1'b1;
      for (k = 0; k < 200 && !cmd_ready_in; k++) @(negedge core_clk_in);
      if (k == 200) late = 1'b1;
      @(posedge core_clk_in);
      #1;
    end
    cmd_valid_out = 1'b0;
    cmd_byte_out  = ~cmd_byte_out;
  endtask

  // push length-1 commands until the block refuses
  task automatic fill(output int n);
    n = 0;
    cmd_valid_out = 1'b1;
    repeat (40) begin
      cmd_byte_out = n[0] ? 8'h03 : 8'h01;
      @(negedge core_clk_in);
      if (!cmd_ready_in) break;
      @(posedge core_clk_in);
      #1 n++;
    end
    @(posedge core_clk_in);
    #1 cmd_valid_out = 1'b0;
  endtask

  // takes n event bytes, stalling a cycle before each
  task automatic get(input int n);
    int k;
    for (int i = 0; i < n && !late; i++) begin
      @(posedge core_clk_in);
      #1 evt_ready_out = 1'b1;
      for (k = 0; k < 400 && !evt_valid_in; k++) @(negedge core_clk_in);
      if (k == 400) late = 1'b1;
      rx[i] = evt_byte_in;
      @(posedge core_clk_in);
      #1 evt_ready_out = 1'b0;
    end
  endtask
endmodule // ptsc_host

// [test/tb.sv]
// tb: self-checking bench for ptsc_cmd with the host model and link/radio responders
// assumes the hand-over reply formats and status codes of ptsc_pkg
`timescale 1ns/1ps

module tb;
  logic                  core_clk_in, nrst_in, cmd_valid, cmd_ready, evt_valid, evt_ready;
  logic [7:0]            cmd_byte, evt_byte, mem_rdata;
  logic                  closed_load, open_req, open_done, open_ok, link_ok, carrier;
  logic [5:0]            open_pipe, pipe_seen, mem_addr;
  logic [63:0]           closed_map, open_map, closed_now;
  ptsc_pkg::ptsc_rx_s    peer_rx, deliver;
  ptsc_pkg::ptsc_radio_s radio;
  logic                  radio_done, radio_ok, uart_req, uart_ready, uart_rsp_v, restored;
  logic [15:0]           uart_cmd, uart_rsp, radio_cmd, radio_evt;
  logic [7:0]            q[$];
  int                    err_count, checked, n_open, k;

  ptsc_cmd ptsc_cmd_inst (
    .core_clk_in(core_clk_in), .nrst_in(nrst_in), .cmd_valid_in(cmd_valid),
    .cmd_ready_out(cmd_ready), .cmd_byte_in(cmd_byte), .evt_valid_out(evt_valid),
    .evt_ready_in(evt_ready), .evt_byte_out(evt_byte), .closed_load_in(closed_load),
    .closed_map_in(closed_map), .open_req_out(open_req), .open_pipe_out(open_pipe),
    .open_done_in(open_done), .open_ok_in(open_ok), .open_map_out(open_map),
    .closed_pipe_map_out(closed_now), .peer_rx_in(peer_rx), .deliver_out(deliver),
    .radio_out(radio), .radio_done_in(radio_done), .radio_ok_in(radio_ok),
    .radio_evt_in(radio_evt), .carrier_out(carrier), .uart_req_in(uart_req),
    .uart_cmd_in(uart_cmd), .uart_ready_out(uart_ready), .uart_rsp_valid_out(uart_rsp_v),
    .uart_rsp_out(uart_rsp), .mem_addr_in(mem_addr), .mem_rdata_out(mem_rdata),
    .state_restored_out(restored)
  );

  ptsc_host ptsc_host_inst (
    .core_clk_in(core_clk_in), .cmd_valid_out(cmd_valid), .cmd_ready_in(cmd_ready),
    .cmd_byte_out(cmd_byte), .evt_valid_in(evt_valid), .evt_ready_out(evt_ready),
    .evt_byte_in(evt_byte)
  );

  initial begin
    core_clk_in = 1'b0;
    forever #2.5 core_clk_in = ~core_clk_in;
  end

  // link and radio answer a few cycles after each request
  always @(negedge core_clk_in) begin
    if (open_req) begin
      n_open++;
      pipe_seen = open_pipe;
      fork
        begin
          repeat (3) @(posedge core_clk_in);
          #1 open_done = 1'b1;
          open_ok = link_ok;
          @(posedge core_clk_in);
          #1 open_done = 1'b0;
        end
      join_none
    end
    if (radio.req) begin
      radio_cmd = radio.cmd;
      fork
        begin
          repeat (4) @(posedge core_clk_in);
          #1 radio_done = 1'b1;
          @(posedge core_clk_in);
          #1 radio_done = 1'b0;
        end
      join_none
    end
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic stop_test;
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic exp(input logic [7:0] e[$]);
    ptsc_host_inst.get(e.size());
    if (ptsc_host_inst.late) begin
      err_count++;
      stop_test;
    end else begin
      foreach (e[i]) chk("event byte", e[i], ptsc_host_inst.rx[i]);
    end
  endtask

  task automatic peer(input logic [5:0] p, input logic e);
    @(posedge core_clk_in);
    #1 peer_rx = '{1'b1, p, 8'h5a};
    @(posedge core_clk_in);
    #1 peer_rx.valid = 1'b0;
    chk("delivered", 16'(e), 16'(deliver.valid));
    if (e) chk("delivered data", 16'h5a, 16'(deliver.data));
  endtask

  task automatic t_fifo;
    int n;
    ptsc_host_inst.fill(n);
    chk("bytes taken", 16'd10, 16'(n));
    repeat (5) exp({8'h03, 8'h84, 8'h03, 8'h83});
    ptsc_host_inst.put({8'h03, 8'h07, 8'h00, 8'h00});
    exp({8'h03, 8'h84, 8'h07, 8'h83});
  endtask

  task automatic t_open;
    @(posedge core_clk_in);
    #1 closed_load = 1'b1;
    @(posedge core_clk_in);
    #1 closed_load = 1'b0;
    peer(6'h05, 1'b0);
    ptsc_host_inst.put({8'h02, 8'h14, 8'h07});
    exp({8'h03, 8'h84, 8'h14, 8'h83});
    chk("open requests", 16'd0, 16'(n_open));
    link_ok = 1'b0;
    ptsc_host_inst.put({8'h02, 8'h14, 8'h06});
    exp({8'h03, 8'h84, 8'h14, 8'h83});
    exp({8'h03, 8'h8d, 8'h06, 8'h83});
    link_ok = 1'b1;
    ptsc_host_inst.put({8'h02, 8'h14, 8'h05});
    exp({8'h03, 8'h84, 8'h14, 8'h00, 8'h11, 8'h80, 8'h20, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
    chk("pipe asked", 16'h05, 16'(pipe_seen));
    chk("open map bit", 16'h1, 16'(open_map[5]));
    chk("closed map", 16'h40, closed_now[15:0]);
    peer(6'h05, 1'b1);
    peer(6'h06, 1'b0);
  endtask

  task automatic t_radio;
    ptsc_host_inst.put({8'h03, 8'h03, 8'h80, 8'h03});
    exp({8'h05, 8'h84, 8'h03, 8'h00, 8'h12, 8'h34});
    chk("radio cmd", 16'h8003, radio_cmd);
    chk("carrier", 16'h1, 16'(carrier));
    for (k = 0; k < 100 && !uart_ready; k++) @(negedge core_clk_in);
    chk("uart ready", 16'h1, 16'(uart_ready));
    if (k == 100) stop_test();
    @(posedge core_clk_in);
    #1 uart_req = 1'b1;
    uart_cmd = 16'h4001;
    @(posedge core_clk_in);
    #1 uart_req = 1'b0;
    for (k = 0; k < 100 && !uart_rsp_v; k++) @(negedge core_clk_in);
    chk("uart reply valid", 16'h1, 16'(uart_rsp_v));
    if (k == 100) stop_test();
    chk("uart reply", 16'h1234, uart_rsp);
    chk("radio cmd", 16'h4001, radio_cmd);
    chk("carrier", 16'h0, 16'(carrier));
    @(posedge core_clk_in);
    #1 radio_ok = 1'b0;
    ptsc_host_inst.put({8'h03, 8'h03, 8'h80, 8'h03});
    exp({8'h03, 8'h84, 8'h03, 8'h83});
    radio_ok = 1'b1;
  endtask

  // an out-of-order packet is refused, then saved packets go back in sequence order and are dumped again
  task automatic t_state;
    for (int s = -1; s < 2; s++) begin
      q = {8'h1d, 8'h08, 8'(s < 0 ? 1 : s)};
      for (int j = 0; j < 27; j++) q.push_back(8'h40 + 8'((s < 0 ? 1 : s) * 27 + j));
      ptsc_host_inst.put(q);
      exp({8'h03, 8'h84, 8'h08, s < 0 ? 8'h83 : (s == 1 ? 8'h02 : 8'h01)});
    end
    chk("restored", 16'h1, 16'(restored));
    mem_addr = 6'h1c;
    repeat (2) @(posedge core_clk_in);
    #1 chk("state byte", 16'h5c, 16'(mem_rdata));
    for (int s = 0; s < 2; s++) begin
      q = {8'h1f, 8'h84, 8'h07, s == 1 ? 8'h02 : 8'h01, 8'(s)};
      for (int j = 0; j < 27; j++) q.push_back(8'h40 + 8'(s * 27 + j));
      ptsc_host_inst.put({8'h01, 8'h07});
      exp(q);
    end
  endtask

  initial begin
    nrst_in     = 1'b0;
    closed_load = 1'b0;
    closed_map  = 64'h60;
    open_done   = 1'b0;
    open_ok     = 1'b0;
    link_ok     = 1'b1;
    peer_rx     = '0;
    radio_done  = 1'b0;
    radio_ok    = 1'b1;
    radio_evt   = 16'h1234;
    uart_req    = 1'b0;
    uart_cmd    = 16'h0;
    mem_addr    = 6'h0;
    err_count   = 0;
    checked     = 0;
    n_open      = 0;
    repeat (16) @(posedge core_clk_in);
    #1 nrst_in = 1'b1;
    t_fifo();
    t_open();
    t_radio();
    t_state();
    stop_test();
  end

  initial begin
    #200000;
    err_count++;
    stop_test();
  end
endmodule // tb
